// >>> common/tx_mod_pkg.sv
// Package: offsets, fields and reset values of the per-port transmit modification registers
`default_nettype none
package tx_mod_pkg;
	localparam int addr_width = 12;
	localparam int data_width = 32;
	localparam int port_count = 3;
	localparam int port_sel_width = 2;
	localparam int bank_sel_width = 3;
	localparam logic [bank_sel_width-1:0] port_bank = 3'h2;
	localparam logic [addr_width-1:0] off_modify_ctrl = 12'h164;
	localparam logic [addr_width-1:0] off_modify_ctrl2 = 12'h168;
	// Bank and port select register (offset is a local choice)
	localparam logic [addr_width-1:0] off_bank_port_sel = 12'h100;
	localparam int bank_sel_lsb = 0;
	localparam int port_sel_lsb = 8;
	localparam int clr_rsvd_bit = 31;
	localparam int suppress_bit = 30;
	localparam int turnaround_bit = 29;
	localparam int sync_insert_bit = 28;
	localparam int rsvd_off_msb = 27;
	localparam int rsvd_off_lsb = 22;
	localparam int sec_off_msb = 21;
	localparam int sec_off_lsb = 16;
	localparam int type_en_msb = 15;
	localparam int checksum_bit = 0;
	localparam logic [5:0] rsvd_off_reset = 6'h10;
	localparam logic [5:0] sec_off_reset = 6'h05;
	localparam logic [15:0] type_en_reset = 16'h000f;
	localparam logic [data_width-1:0] modify_ctrl_reset =
		{4'h0, rsvd_off_reset, sec_off_reset, type_en_reset};
	localparam logic [3:0] msg_type_sync = 4'h0;
	localparam logic [3:0] msg_type_peer_resp = 4'h3;
endpackage
`default_nettype wire

// >>> rtl/port_cfg_mem.sv
// Per-port register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module port_cfg_mem #(
	parameter int depth = 3,
	parameter int width = 32,
	parameter logic [31:0] reset_value = 32'h0000_0000
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Write port
	input wire logic i_we,
	input wire logic [$clog2(depth)-1:0] i_waddr,
	input wire logic [width-1:0] i_wdata,
	// Read port
	input wire logic [$clog2(depth)-1:0] i_raddr,
	output logic [width-1:0] o_rdata,
	// Full contents for the datapath
	output logic [depth*width-1:0] o_all
);
	logic [width-1:0] mem [depth];
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			for (int i = 0; i < depth; i++)
				mem[i] <= reset_value[width-1:0];
			o_rdata <= '0;
		end
		else
		begin
			if (i_we && (int'(i_waddr) < depth))
				mem[i_waddr] <= i_wdata;
			o_rdata <= (int'(i_raddr) < depth) ? mem[i_raddr] : '0;
		end
	end
	always_comb
	begin
		for (int i = 0; i < depth; i++)
			o_all[i*width +: width] = mem[i];
	end
endmodule
`default_nettype wire

// >>> rtl/ptp_tx_message_modify_config.sv
// Per-port transmit timing-message modification registers and frame decisions
//
// Functional notes
// - Bit 31: zero four reserved bytes if modified
// - Bit 30: no egress stamp after correction edit
// - Bit 29: add turnaround to host peer responses
// - Bit 28: egress time into host sync
// - Bits 27:22 locate the four reserved bytes
// - Bits 21:16 locate ingress seconds, reset 5
// - Bits 15:0 enable correction edit per type
// - Second register bit 0 clears UDP checksum on turnaround or sync insert
// - Bank 2, port-selected before access
`timescale 1ns/1ps
`default_nettype none
module ptp_tx_message_modify_config
	import tx_mod_pkg::*;
#(
	parameter int ports = tx_mod_pkg::port_count
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [tx_mod_pkg::addr_width-1:0] i_addr,
	input wire logic [tx_mod_pkg::data_width-1:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [tx_mod_pkg::data_width-1:0] o_rdata,
	// Timing engine state
	input wire logic i_engine_enable,
	// Frame under transmission
	input wire logic i_frame_valid,
	input wire logic [tx_mod_pkg::port_sel_width-1:0] i_frame_port,
	input wire logic [3:0] i_frame_msg_type,
	input wire logic i_frame_host_sent,
	input wire logic i_frame_is_udp_ipv4,
	// Per-frame decisions, registered one cycle after i_frame_valid; o_engine_busy follows i_engine_enable unregistered
	output logic o_dec_valid,
	output logic o_cf_edit,
	output logic o_clear_rsvd,
	output logic [5:0] o_rsvd_offset,
	output logic [5:0] o_sec_offset,
	output logic o_suppress_stamp,
	output logic o_turnaround_insert,
	output logic o_sync_insert,
	output logic o_clear_checksum,
	output logic o_engine_busy
);
	import tx_mod_pkg::*;

	localparam int pw = $clog2(ports);

	logic [bank_sel_width-1:0] bank_sel;
	logic [port_sel_width-1:0] port_sel;
	logic [ports-1:0] chk_clear;
	logic read_d;
	logic [1:0] read_src;
	logic [data_width-1:0] ctrl_rdata;
	logic [ports*data_width-1:0] ctrl_all;

	// Port numbers beyond the last port select nothing
	function automatic logic port_in_range(input logic [port_sel_width-1:0] p);
		return int'(p) < ports;
	endfunction

	// Register decode; control registers within the selected bank, select register in any bank
	wire in_bank = (bank_sel == port_bank);
	wire port_ok = port_in_range(port_sel);
	wire hit_ctrl = in_bank && port_ok && (i_addr == off_modify_ctrl);
	wire hit_ctrl2 = in_bank && port_ok && (i_addr == off_modify_ctrl2);
	wire hit_sel = (i_addr == off_bank_port_sel);
	wire wr_ctrl = i_write && hit_ctrl;
	wire wr_ctrl2 = i_write && hit_ctrl2;
	wire wr_sel = i_write && hit_sel;
	wire [pw-1:0] port_idx = pw'(port_sel);

	port_cfg_mem #(
		.depth(ports),
		.width(data_width),
		.reset_value(modify_ctrl_reset)
	) u_ctrl_mem (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_we(wr_ctrl),
		.i_waddr(port_idx),
		.i_wdata(i_wdata),
		.i_raddr(port_idx),
		.o_rdata(ctrl_rdata),
		.o_all(ctrl_all)
	);

	// Bank and port select
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			bank_sel <= '0;
			port_sel <= '0;
		end
		else if (wr_sel)
		begin
			bank_sel <= i_wdata[bank_sel_lsb +: bank_sel_width];
			port_sel <= i_wdata[port_sel_lsb +: port_sel_width];
		end
	end

	// Only bit 0 stored in second register
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			chk_clear <= '0;
		else if (wr_ctrl2)
			chk_clear[port_idx] <= i_wdata[checksum_bit];
	end

	// Read source captured with the strobe, data muxed next cycle
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			read_d <= 1'h0;
			read_src <= 2'h0;
		end
		else
		begin
			read_d <= i_read;
			read_src <= hit_ctrl ? 2'h1 : hit_ctrl2 ? 2'h2 : hit_sel ? 2'h3 : 2'h0;
		end
	end

	logic [data_width-1:0] sel_word;
	logic [data_width-1:0] ctrl2_word;
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sel_word <= '0;
			ctrl2_word <= '0;
		end
		else
		begin
			// Port field at bits 9:8, bank at bits 2:0
			sel_word <= data_width'({6'h00, port_sel, 5'h00, bank_sel});
			ctrl2_word <= data_width'(port_ok ? chk_clear[port_idx] : 1'h0);
		end
	end

	// Unmapped reads and reads outside the window return zero
	always_comb
	begin
		o_rdata = '0;
		if (read_d)
		begin
			case (read_src)
				2'h1: o_rdata = ctrl_rdata;
				2'h2: o_rdata = ctrl2_word;
				2'h3: o_rdata = sel_word;
				default: o_rdata = '0;
			endcase
		end
	end

	// Datapath view of the frame's port settings
	wire frame_port_ok = port_in_range(i_frame_port);
	wire [pw-1:0] fport = pw'(i_frame_port);
	wire [data_width-1:0] fctrl = frame_port_ok ? ctrl_all[fport*data_width +: data_width] : '0;
	wire fchk = frame_port_ok ? chk_clear[fport] : 1'h0;

	wire cf_edit = fctrl[i_frame_msg_type];
	wire ta_ins = fctrl[turnaround_bit] && i_frame_host_sent
		&& (i_frame_msg_type == msg_type_peer_resp);
	wire sync_ins = fctrl[sync_insert_bit] && i_frame_host_sent
		&& (i_frame_msg_type == msg_type_sync);
	wire modified = cf_edit || ta_ins || sync_ins;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_dec_valid <= 1'h0;
			o_cf_edit <= 1'h0;
			o_clear_rsvd <= 1'h0;
			o_rsvd_offset <= rsvd_off_reset;
			o_sec_offset <= sec_off_reset;
			o_suppress_stamp <= 1'h0;
			o_turnaround_insert <= 1'h0;
			o_sync_insert <= 1'h0;
			o_clear_checksum <= 1'h0;
		end
		else
		begin
			o_dec_valid <= i_frame_valid;
			o_cf_edit <= i_frame_valid && cf_edit;
			o_clear_rsvd <= i_frame_valid && fctrl[clr_rsvd_bit] && modified;
			o_rsvd_offset <= fctrl[rsvd_off_msb:rsvd_off_lsb];
			o_sec_offset <= fctrl[sec_off_msb:sec_off_lsb];
			o_suppress_stamp <= i_frame_valid && fctrl[suppress_bit] && cf_edit;
			o_turnaround_insert <= i_frame_valid && ta_ins;
			o_sync_insert <= i_frame_valid && sync_ins;
			o_clear_checksum <= i_frame_valid && fchk && i_frame_is_udp_ipv4
				&& (ta_ins || sync_ins);
		end
	end

	// Engine state shown; static fields are the host's duty
	assign o_engine_busy = i_engine_enable;
endmodule
`default_nettype wire

// >>> verification/tx_mod_asserts.sv
// Checker of frame decision timing and read data gating
`timescale 1ns/1ps
`default_nettype none
module tx_mod_asserts
	import tx_mod_pkg::*;
#(
	parameter int ports = 3
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire logic i_read,
	input wire logic [tx_mod_pkg::data_width-1:0] o_rdata,
	// Frame and decisions
	input wire logic i_frame_valid,
	input wire logic [tx_mod_pkg::port_sel_width-1:0] i_frame_port,
	input wire logic [3:0] i_frame_msg_type,
	input wire logic i_frame_host_sent,
	input wire logic i_frame_is_udp_ipv4,
	input wire logic o_dec_valid,
	input wire logic o_cf_edit,
	input wire logic o_clear_rsvd,
	input wire logic o_suppress_stamp,
	input wire logic o_turnaround_insert,
	input wire logic o_sync_insert,
	input wire logic o_clear_checksum
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	dec_pulse_a: assert property (i_frame_valid |=> o_dec_valid) else $error("no decision");
	dec_cause_a: assert property (o_dec_valid |-> $past(i_frame_valid)) else $error("stray decision");
	peer_resp_a: assert property (o_turnaround_insert |-> o_dec_valid && $past(i_frame_host_sent)
		&& $past(i_frame_msg_type) == msg_type_peer_resp) else $error("bad turnaround");
	sync_ins_a: assert property (o_sync_insert |-> o_dec_valid && $past(i_frame_host_sent)
		&& $past(i_frame_msg_type) == msg_type_sync) else $error("bad sync insert");
	chksum_clr_a: assert property (o_clear_checksum |-> $past(i_frame_is_udp_ipv4)
		&& (o_turnaround_insert || o_sync_insert)) else $error("bad checksum clear");
	rsvd_clr_a: assert property (o_clear_rsvd |-> o_cf_edit || o_turnaround_insert || o_sync_insert)
		else $error("clear without edit");
	suppress_a: assert property (o_suppress_stamp |-> o_cf_edit && o_dec_valid)
		else $error("bad suppress");
	bad_port_a: assert property (i_frame_valid && i_frame_port >= ports |=> !(o_cf_edit
		|| o_clear_rsvd || o_turnaround_insert || o_sync_insert)) else $error("flags on bad port");
	rdata_gate_a: assert property (!$past(i_read) |-> o_rdata == '0) else $error("read data leak");
endmodule
bind ptp_tx_message_modify_config tx_mod_asserts #(.ports(ports)) chk (.i_clk(i_clk),
	.i_reset(i_reset), .i_read(i_read), .o_rdata(o_rdata), .i_frame_valid(i_frame_valid),
	.i_frame_port(i_frame_port), .i_frame_msg_type(i_frame_msg_type),
	.i_frame_host_sent(i_frame_host_sent), .i_frame_is_udp_ipv4(i_frame_is_udp_ipv4),
	.o_dec_valid(o_dec_valid), .o_cf_edit(o_cf_edit), .o_clear_rsvd(o_clear_rsvd),
	.o_suppress_stamp(o_suppress_stamp), .o_turnaround_insert(o_turnaround_insert),
	.o_sync_insert(o_sync_insert), .o_clear_checksum(o_clear_checksum));
`default_nettype wire

// >>> verification/ptp_tx_message_modify_config_tb.sv
// Register and frame decision tests for the transmit modification block
`timescale 1ns/1ps
`default_nettype none
module ptp_tx_message_modify_config_tb;
	import tx_mod_pkg::*;
	logic i_clk = 1'h0, i_reset = 1'h1, wr = 1'h0, rd = 1'h0, en = 1'h0;
	logic fv = 1'h0, fh = 1'h0, fu = 1'h0, dv, cf, cr, sup, ta, si, cc, busy;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h0, rdata;
	logic [1:0] fp = 2'h0;
	logic [3:0] ft = 4'h0;
	logic [5:0] ro, so;
	int n_fail = 0, samples_checked = 0;
	ptp_tx_message_modify_config dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr),
		.i_wdata(wd), .i_write(wr), .i_read(rd), .o_rdata(rdata), .i_engine_enable(en),
		.i_frame_valid(fv), .i_frame_port(fp), .i_frame_msg_type(ft), .i_frame_host_sent(fh),
		.i_frame_is_udp_ipv4(fu), .o_dec_valid(dv), .o_cf_edit(cf), .o_clear_rsvd(cr),
		.o_rsvd_offset(ro), .o_sec_offset(so), .o_suppress_stamp(sup),
		.o_turnaround_insert(ta), .o_sync_insert(si), .o_clear_checksum(cc), .o_engine_busy(busy));
	task automatic test_done();
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge i_clk);
		wr <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge i_clk);
		rd <= 1'h0;
		#1 check(rdata, exp);
	endtask
	// Flags packed as edit, clear, suppress, turnaround, sync, checksum
	task automatic frame(input logic [1:0] p, input logic [3:0] t, input logic h, input logic u,
		input logic [5:0] exp);
		@(posedge i_clk);
		fp <= p;
		ft <= t;
		fh <= h;
		fu <= u;
		fv <= 1'h1;
		@(posedge i_clk);
		fv <= 1'h0;
		#1 check({26'h0, cf, cr, sup, ta, si, cc}, {26'h0, exp});
	endtask
	initial
	begin
		forever #4 i_clk = ~i_clk;
	end
	initial
	begin
		#20000 n_fail++;
		test_done();
	end
	initial
	begin
		repeat (2) @(posedge i_clk);
		i_reset <= 1'h0;
		wr_reg(off_bank_port_sel, 32'h0000_0002);
		rd_reg(off_bank_port_sel, 32'h0000_0002);
		rd_reg(off_modify_ctrl, 32'h0405_000f);
		rd_reg(off_modify_ctrl2, 32'h0000_0000);
		frame(2'h0, 4'h0, 1'h0, 1'h0, 6'h20);
		frame(2'h0, 4'h4, 1'h1, 1'h1, 6'h00);
		check({20'h0, ro, so}, {20'h0, 6'h10, 6'h05});
		wr_reg(off_modify_ctrl, 32'hf0c7_0011);
		wr_reg(off_modify_ctrl2, 32'hffff_ffff);
		rd_reg(off_modify_ctrl2, 32'h0000_0001);
		rd_reg(off_modify_ctrl, 32'hf0c7_0011);
		// Static fields settled before the engine runs
		@(posedge i_clk);
		en <= 1'h1;
		frame(2'h0, 4'h0, 1'h1, 1'h1, 6'h3b);
		frame(2'h0, 4'h3, 1'h1, 1'h1, 6'h15);
		frame(2'h0, 4'h4, 1'h0, 1'h0, 6'h38);
		frame(2'h0, 4'h3, 1'h1, 1'h0, 6'h14);
		frame(2'h0, 4'h0, 1'h0, 1'h1, 6'h38);
		frame(2'h0, 4'h5, 1'h0, 1'h1, 6'h00);
		check({20'h0, ro, so}, {20'h0, 6'h03, 6'h07});
		check({31'h0, busy}, 32'h0000_0001);
		wr_reg(off_bank_port_sel, 32'h0000_0102);
		rd_reg(off_bank_port_sel, 32'h0000_0102);
		rd_reg(off_modify_ctrl, 32'h0405_000f);
		frame(2'h1, 4'h0, 1'h1, 1'h1, 6'h20);
		frame(2'h3, 4'h0, 1'h1, 1'h1, 6'h00);
		wr_reg(off_bank_port_sel, 32'h0000_0001);
		wr_reg(off_modify_ctrl, 32'h0000_0000);
		rd_reg(off_modify_ctrl, 32'h0000_0000);
		wr_reg(off_bank_port_sel, 32'h0000_0302);
		rd_reg(off_modify_ctrl, 32'h0000_0000);
		wr_reg(off_bank_port_sel, 32'h0000_0002);
		rd_reg(off_modify_ctrl, 32'hf0c7_0011);
		rd_reg(12'h16c, 32'h0000_0000);
		test_done();
	end
endmodule
`default_nettype wire
